// ===== design/ctm_pkg.sv
// Package of constants and types for the compact timer block.
// Assumes a single 40 MHz clock domain and an Avalon-MM register slave.

package ctm_pkg;

    // ************************************************************
    // Register map, word offsets in bytes.
    // ************************************************************
    localparam logic [4:0] CTM_OFS_CTRL0    = 5'h00;
    localparam logic [4:0] CTM_OFS_CTRL1    = 5'h04;
    localparam logic [4:0] CTM_OFS_CNT_LO   = 5'h08;
    localparam logic [4:0] CTM_OFS_CNT_HI   = 5'h0C;
    localparam logic [4:0] CTM_OFS_CMP_LO   = 5'h10;
    localparam logic [4:0] CTM_OFS_CMP_HI   = 5'h14;
    localparam logic [4:0] CTM_OFS_STATUS   = 5'h18;

    // ************************************************************
    // Reset values and widths.
    // ************************************************************
    localparam int         CTM_CNT_W        = 10;
    localparam logic [7:0] CTM_CTRL_RST     = 8'h00;
    localparam logic [9:0] CTM_CNT_RST      = 10'h000;
    localparam logic [1:0] CTM_STAT_RST     = 2'h0;
    localparam logic [7:0] CTM_RDATA_UNMAP  = 8'h00;

    // ************************************************************
    // Clock source selections and divider ratios.
    // ************************************************************
    localparam logic [2:0] CTM_CK_SYS4      = 3'h0;
    localparam logic [2:0] CTM_CK_SYS       = 3'h1;
    localparam logic [2:0] CTM_CK_H16       = 3'h2;
    localparam logic [2:0] CTM_CK_H64       = 3'h3;
    localparam logic [2:0] CTM_CK_SUB0      = 3'h4;
    localparam logic [2:0] CTM_CK_SUB1      = 3'h5;
    localparam logic [2:0] CTM_CK_PIN_RISE  = 3'h6;
    localparam logic [2:0] CTM_CK_PIN_FALL  = 3'h7;
    localparam int         CTM_DIV_SYS      = 4;
    localparam int         CTM_DIV_H16      = 16;
    localparam int         CTM_DIV_H64      = 64;

    // ************************************************************
    // Output action codes and modes.
    // ************************************************************
    localparam logic [1:0] CTM_IO_NONE      = 2'h0;
    localparam logic [1:0] CTM_IO_LOW       = 2'h1;
    localparam logic [1:0] CTM_IO_HIGH      = 2'h2;
    localparam logic [1:0] CTM_IO_TOGGLE    = 2'h3;

    typedef enum logic [1:0] {
        CTM_MODE_COMPARE = 2'h0,
        CTM_MODE_UNDEF   = 2'h1,
        CTM_MODE_PWM     = 2'h2,
        CTM_MODE_TIMER   = 2'h3
    } ctm_mode_t;

    // Control register 0 layout.
    typedef struct packed {
        logic       pause;
        logic [2:0] count_clock_select;
        logic       timer_on_control;
        logic [2:0] period_compare_value;
    } ctm_ctrl0_t;

    // Control register 1 layout.
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] io_action;
        logic       out_init;
        logic       out_invert;
        logic       duty_period_sel;
        logic       clear_on_a;
    } ctm_ctrl1_t;

endpackage : ctm_pkg

// ===== design/ctm_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is asynchronous to CLOCK.
`timescale 1ns/1ps
`default_nettype none

module ctm_sync (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Level in and out.
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : ctm_sync

`default_nettype wire

// ===== design/ctm_div.sv
// Free-running clock divider that emits one enable pulse per period.
// Assumes the source tick is a single-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ctm_div #(
    parameter int RATIO = 4
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Source tick and divided tick.
    input  wire logic tick_in,
    output logic      tick_out
);
    localparam int W = $clog2(RATIO);
    localparam logic [W-1:0] LAST = W'(RATIO - 1);

    logic [W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && (cnt_q == LAST);
            if (tick_in) begin
                cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
            end
        end
    end

endmodule : ctm_div

`default_nettype wire

// ===== design/ctm_top.sv
// Compact timer: ten-bit up-counter, two comparators, two outputs, PWM.
// Assumes an Avalon-MM master on CLOCK; the high clock and the sub clock
// arrive as asynchronous square waves and are sampled on CLOCK.
`timescale 1ns/1ps
`default_nettype none

module ctm_top
    import ctm_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // Avalon-MM register slave.
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Other internal clocks, sampled as levels.
    input  wire logic        INTERNAL_HIGH_CLOCK,
    input  wire logic        SUB_CLOCK,
    // Pin-shared selection for the timer pins.
    input  wire logic        PIN_SEL_COUNT_IN,
    input  wire logic        PIN_SEL_OUT_POS,
    input  wire logic        PIN_SEL_OUT_NEG,
    // External count pin.
    input  wire logic        EXTERNAL_COUNT_PIN,
    // Timer output pins.
    output logic             TIMER_OUT_POS,
    output logic             TIMER_OUT_POS_OE,
    output logic             TIMER_OUT_NEG,
    output logic             TIMER_OUT_NEG_OE,
    // Interrupt requests, one-cycle pulses.
    output logic             IRQ_COMPARE_A,
    output logic             IRQ_PERIOD
);

    // ************************************************************
    // Registers.
    // ************************************************************
    ctm_ctrl0_t  ctrl0_q;
    ctm_ctrl1_t  ctrl1_q;
    logic [9:0]  cnt_q;
    logic [9:0]  cmp_q;
    logic [7:0]  buf_q;
    logic [1:0]  stat_q;
    logic        out_q;
    logic        on_d1_q;
    logic        ack_q;
    logic        wreq_q;
    logic [7:0]  rd_q;

    // ************************************************************
    // Input synchronisers and edge detection.
    // ************************************************************
    logic pin_s;
    logic high_s;
    logic sub_s;
    logic pin_prev_q;
    logic high_prev_q;
    logic sub_prev_q;

    ctm_sync u_sync_pin (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .d     (EXTERNAL_COUNT_PIN & PIN_SEL_COUNT_IN),
        .q     (pin_s)
    );
    ctm_sync u_sync_high (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .d     (INTERNAL_HIGH_CLOCK),
        .q     (high_s)
    );
    ctm_sync u_sync_sub (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .d     (SUB_CLOCK),
        .q     (sub_s)
    );

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pin_prev_q  <= 1'b0;
            high_prev_q <= 1'b0;
            sub_prev_q  <= 1'b0;
        end else begin
            pin_prev_q  <= pin_s;
            high_prev_q <= high_s;
            sub_prev_q  <= sub_s;
        end
    end

    wire pin_rise  = pin_s & ~pin_prev_q;
    wire pin_fall  = ~pin_s & pin_prev_q;
    wire high_tick = high_s & ~high_prev_q;
    wire sub_tick  = sub_s & ~sub_prev_q;

    // ************************************************************
    // Clock source selection.
    // ************************************************************
    logic sys4_tick;
    logic h16_tick;
    logic h64_tick;

    ctm_div #(.RATIO(CTM_DIV_SYS)) u_div_sys (
        .clk      (CLOCK),
        .rst_n    (RSTN),
        .tick_in  (1'b1),
        .tick_out (sys4_tick)
    );
    ctm_div #(.RATIO(CTM_DIV_H16)) u_div_h16 (
        .clk      (CLOCK),
        .rst_n    (RSTN),
        .tick_in  (high_tick),
        .tick_out (h16_tick)
    );
    ctm_div #(.RATIO(CTM_DIV_H64)) u_div_h64 (
        .clk      (CLOCK),
        .rst_n    (RSTN),
        .tick_in  (high_tick),
        .tick_out (h64_tick)
    );

    logic count_tick;
    always_comb begin
        case (ctrl0_q.count_clock_select)
            CTM_CK_SYS4:     count_tick = sys4_tick;
            CTM_CK_SYS:      count_tick = 1'b1;
            CTM_CK_H16:      count_tick = h16_tick;
            CTM_CK_H64:      count_tick = h64_tick;
            CTM_CK_PIN_RISE: count_tick = pin_rise;
            CTM_CK_PIN_FALL: count_tick = pin_fall;
            default:         count_tick = sub_tick;
        endcase
    end

    // ************************************************************
    // Comparators.
    // ************************************************************
    ctm_mode_t mode;
    assign mode = ctm_mode_t'(ctrl1_q.mode);

    wire        on_rise  = ctrl0_q.timer_on_control & ~on_d1_q;
    wire        running  = ctrl0_q.timer_on_control & ~ctrl0_q.pause;
    wire        adv      = running & count_tick;
    wire [9:0]  cnt_inc  = cnt_q + 10'h001;
    wire        match_a  = adv && (cnt_inc == cmp_q);
    // A period field of zero matches on the wrap to zero, as overflow.
    wire        match_p  = adv
                          && (cnt_inc[9:7] == ctrl0_q.period_compare_value)
                          && (cnt_inc[6:0] == 7'h00);
    wire        overflow = adv && (cnt_q == 10'h3FF);
    wire        clr_a    = match_a & ctrl1_q.clear_on_a;
    wire        clr_p    = match_p & ~ctrl1_q.clear_on_a;
    // In PWM mode the duty select picks which comparator ends the period.
    wire        pwm_end  = ctrl1_q.duty_period_sel ? match_a : match_p;
    wire        pwm_duty = ctrl1_q.duty_period_sel ? match_p : match_a;

    // ************************************************************
    // Counter.
    // ************************************************************
    logic [9:0] cnt_d;
    always_comb begin
        if (on_rise) begin
            cnt_d = CTM_CNT_RST;
        end else if (!adv) begin
            cnt_d = cnt_q;
        end else if (mode == CTM_MODE_PWM) begin
            cnt_d = pwm_end ? CTM_CNT_RST : cnt_inc;
        end else if (clr_a || clr_p) begin
            cnt_d = CTM_CNT_RST;
        end else begin
            cnt_d = cnt_inc;
        end
    end

    // ************************************************************
    // Output level.
    // ************************************************************
    logic out_d;
    always_comb begin
        out_d = out_q;
        if (on_rise) begin
            out_d = ctrl1_q.out_init;
        end else if (mode == CTM_MODE_COMPARE && match_a) begin
            case (ctrl1_q.io_action)
                CTM_IO_LOW:    out_d = 1'b0;
                CTM_IO_HIGH:   out_d = 1'b1;
                CTM_IO_TOGGLE: out_d = ~out_q;
                default:       out_d = out_q;
            endcase
        end else if (mode == CTM_MODE_PWM) begin
            case (ctrl1_q.io_action)
                CTM_IO_NONE: out_d = ctrl1_q.out_init;
                CTM_IO_LOW:  out_d = ~ctrl1_q.out_init;
                CTM_IO_HIGH: begin
                    if (pwm_end && adv) begin
                        out_d = ~ctrl1_q.out_init;
                    end else if (pwm_duty) begin
                        out_d = ctrl1_q.out_init;
                    end
                end
                default: out_d = out_q;
            endcase
        end
    end

    // ************************************************************
    // Avalon-MM decode. Each access is answered one cycle after it
    // starts: waitrequest is high in the first cycle, low in the next.
    // ************************************************************
    wire        req      = (AVS_READ | AVS_WRITE) & ~ack_q;
    wire        wr_go    = AVS_WRITE & ack_q;
    wire        rd_go    = AVS_READ & ack_q;
    wire        lane0    = AVS_BYTEENABLE[0];
    wire        lane1    = AVS_BYTEENABLE[1];
    wire [7:0]  wdata    = AVS_WRITEDATA[7:0];
    wire        a_ctrl0  = AVS_ADDRESS == CTM_OFS_CTRL0;
    wire        a_ctrl1  = AVS_ADDRESS == CTM_OFS_CTRL1;
    wire        a_cnt_lo = AVS_ADDRESS == CTM_OFS_CNT_LO;
    wire        a_cnt_hi = AVS_ADDRESS == CTM_OFS_CNT_HI;
    wire        a_cmp_lo = AVS_ADDRESS == CTM_OFS_CMP_LO;
    wire        a_cmp_hi = AVS_ADDRESS == CTM_OFS_CMP_HI;
    wire        a_stat   = AVS_ADDRESS == CTM_OFS_STATUS;
    wire        stat_clr = wr_go & a_stat & lane0;

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = CTM_RDATA_UNMAP;
        if (a_ctrl0) rd_mux = ctrl0_q;
        if (a_ctrl1) rd_mux = ctrl1_q;
        if (a_cnt_lo || a_cmp_lo) rd_mux = buf_q;
        if (a_cnt_hi) rd_mux = {6'h00, cnt_q[9:8]};
        if (a_cmp_hi) rd_mux = {6'h00, cmp_q[9:8]};
        if (a_stat) rd_mux = {6'h00, stat_q};
    end

    // Sticky flags: hardware set wins over a software clear.
    wire [1:0] stat_d = (stat_clr ? (stat_q & ~wdata[1:0]) : stat_q)
                        | {match_p, match_a};

    // ************************************************************
    // State update.
    // ************************************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl0_q <= CTM_CTRL_RST;
            ctrl1_q <= CTM_CTRL_RST;
            on_d1_q <= 1'b0;
            ack_q   <= 1'b0;
            wreq_q  <= 1'b1;
            rd_q    <= CTM_RDATA_UNMAP;
            stat_q  <= CTM_STAT_RST;
            cnt_q   <= CTM_CNT_RST;
            out_q   <= 1'b0;
        end else begin
            ack_q   <= req;
            wreq_q  <= ~req;
            on_d1_q <= ctrl0_q.timer_on_control;
            stat_q  <= stat_d;
            cnt_q   <= cnt_d;
            out_q   <= out_d;
            if (req) rd_q <= rd_mux;
            if (wr_go && a_ctrl0 && lane0) ctrl0_q <= ctm_ctrl0_t'(wdata);
            if (wr_go && a_ctrl1 && lane0) ctrl1_q <= ctm_ctrl1_t'(wdata);
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            cmp_q <= CTM_CNT_RST;
            buf_q <= 8'h00;
        end else if (wr_go && a_cmp_lo && lane0) begin
            buf_q <= wdata;
        end else if (wr_go && a_cmp_hi && lane0) begin
            cmp_q <= {wdata[1:0], buf_q};
        end else if (rd_go && a_cnt_hi) begin
            buf_q <= cnt_q[7:0];
        end else if (rd_go && a_cmp_hi) begin
            buf_q <= cmp_q[7:0];
        end
    end

    // ************************************************************
    // Output registers.
    // ************************************************************
    wire drive = ctrl0_q.timer_on_control && mode != CTM_MODE_TIMER;
    wire lvl   = out_q ^ ctrl1_q.out_invert;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            TIMER_OUT_POS    <= 1'b0;
            TIMER_OUT_NEG    <= 1'b0;
            TIMER_OUT_POS_OE <= 1'b0;
            TIMER_OUT_NEG_OE <= 1'b0;
            IRQ_COMPARE_A    <= 1'b0;
            IRQ_PERIOD       <= 1'b0;
        end else begin
            TIMER_OUT_POS    <= lvl;
            TIMER_OUT_NEG    <= ~lvl;
            TIMER_OUT_POS_OE <= drive & PIN_SEL_OUT_POS;
            TIMER_OUT_NEG_OE <= drive & PIN_SEL_OUT_NEG;
            IRQ_COMPARE_A    <= match_a;
            IRQ_PERIOD       <= match_p | overflow;
        end
    end

    assign AVS_READDATA    = {24'h000000, rd_q};
    assign AVS_WAITREQUEST = wreq_q;

endmodule : ctm_top

`default_nettype wire

// ===== tb/ctm_checker.sv
// Port-level checks for the compact timer block.
// Assumes it is bound to ctm_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ctm_checker (
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // Register bus.
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_READDATA,
    input  wire logic        AVS_WAITREQUEST,
    // Pin selection and outputs.
    input  wire logic        PIN_SEL_OUT_POS,
    input  wire logic        PIN_SEL_OUT_NEG,
    input  wire logic        TIMER_OUT_POS,
    input  wire logic        TIMER_OUT_POS_OE,
    input  wire logic        TIMER_OUT_NEG,
    input  wire logic        TIMER_OUT_NEG_OE
);
    wire req = AVS_READ || AVS_WRITE;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    // ************************************************************
    // Bus answer and pin relations.
    // ************************************************************
    bus_answer_a: assert property (req && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("request left waiting");
    answer_once_a: assert property (!AVS_WAITREQUEST
        |=> AVS_WAITREQUEST) else $error("answer held too long");
    no_req_idle_a: assert property (!req
        |=> AVS_WAITREQUEST) else $error("answer without request");
    rdata_upper_a: assert property (!AVS_WAITREQUEST
        |-> AVS_READDATA[31:8] == 24'h0) else $error("upper data set");
    rdata_hold_a: assert property (!AVS_WAITREQUEST
        |=> $stable(AVS_READDATA)) else $error("read data moved");
    pos_gate_a: assert property (TIMER_OUT_POS_OE
        |-> $past(PIN_SEL_OUT_POS)) else $error("pos pin not selected");
    neg_gate_a: assert property (TIMER_OUT_NEG_OE
        |-> $past(PIN_SEL_OUT_NEG)) else $error("neg pin not selected");
    pins_compl_a: assert property (TIMER_OUT_POS_OE && TIMER_OUT_NEG_OE
        |-> TIMER_OUT_NEG != TIMER_OUT_POS) else $error("pins not opposite");

endmodule : ctm_checker

`default_nettype wire

// ===== tb/test_ctm_top.sv
// Self-checking bench for the compact timer, driven over Avalon-MM.
// Assumes the ctm_pkg package and the ctm_checker module are compiled.
`timescale 1ns/1ps
`default_nettype none

module test_ctm_top
    import ctm_pkg::*;
;
    logic        clk, rst_n, rd, wr, wreq, hclk, sclk, pin;
    logic        sel_in, sel_pos, sel_neg, pos, pos_oe, neg, neg_oe;
    logic        irq_a, irq_p;
    logic [4:0]  adr;
    logic [3:0]  be;
    logic [31:0] wdat, rdat, q;
    logic [9:0]  c;
    int          bad_count, total_checks, hi_n;

    ctm_top u_dut (.CLOCK(clk), .RSTN(rst_n), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .INTERNAL_HIGH_CLOCK(hclk), .SUB_CLOCK(sclk),
        .PIN_SEL_COUNT_IN(sel_in), .PIN_SEL_OUT_POS(sel_pos),
        .PIN_SEL_OUT_NEG(sel_neg), .EXTERNAL_COUNT_PIN(pin),
        .TIMER_OUT_POS(pos), .TIMER_OUT_POS_OE(pos_oe),
        .TIMER_OUT_NEG(neg), .TIMER_OUT_NEG_OE(neg_oe),
        .IRQ_COMPARE_A(irq_a), .IRQ_PERIOD(irq_p));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The high clock rises every second cycle, the sub clock every fourth.
    always @(posedge clk) begin
        hclk <= ~hclk;
        if (hclk) sclk <= ~sclk;
    end

    // ************************************************************
    // Checking and bus tasks.
    // ************************************************************
    task automatic test_done;
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq === 1'b0) begin
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk);
        end else begin
            bad_count++;
            $display("BAD %0t bus timeout", $time);
            test_done();
        end
    endtask : bus

    task automatic wrb(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wrb

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk_reg(q, e);
    endtask : rdc

    task automatic pulse(input int n);
        repeat (n) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pulse

    task automatic wait_irq(input logic per, input int lim);
        int n;
        n = 0;
        while ((per ? irq_p : irq_a) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk_bit(n < lim, 1'b1);
    endtask : wait_irq

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        {rst_n, rd, wr, hclk, sclk, pin, sel_in, sel_pos, sel_neg} = '0;
        {adr, wdat, bad_count, total_checks} = '0;
        be = 4'hF;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 5; k++) rdc(5'(k * 4), 32'h0);
        wrb(CTM_OFS_CMP_LO, 8'h5A);
        wrb(CTM_OFS_CMP_HI, 8'h02);
        rdc(CTM_OFS_CMP_HI, 32'h2);
        rdc(CTM_OFS_CMP_LO, 32'h5A);
        wrb(CTM_OFS_CMP_LO, 8'h33);
        rdc(CTM_OFS_CMP_HI, 32'h2);
        rdc(CTM_OFS_CMP_LO, 32'h5A);
        wrb(CTM_OFS_CTRL1, 8'hC0);
        rdc(CTM_OFS_CTRL1, 32'hC0);
        sel_in <= 1'b1;
        wrb(CTM_OFS_CTRL0, 8'h68);
        pulse(5);
        rdc(CTM_OFS_CNT_HI, 32'h0);
        pulse(2);
        rdc(CTM_OFS_CNT_LO, 32'h5);
        wrb(CTM_OFS_CTRL0, 8'h78);
        pulse(3);
        rdc(CTM_OFS_CNT_HI, 32'h0);
        rdc(CTM_OFS_CNT_LO, 32'hA);
        sel_in <= 1'b0;
        pulse(3);
        rdc(CTM_OFS_CNT_HI, 32'h0);
        rdc(CTM_OFS_CNT_LO, 32'hA);
        wrb(CTM_OFS_CTRL0, 8'h70);
        wrb(CTM_OFS_CTRL0, 8'h78);
        rdc(CTM_OFS_CNT_HI, 32'h0);
        rdc(CTM_OFS_CNT_LO, 32'h0);
        for (int k = 0; k < 6; k++) begin
            wrb(CTM_OFS_CTRL0, 8'h00);
            wrb(CTM_OFS_CTRL0, {1'b0, k[2:0], 4'b1000});
            repeat (300) @(posedge clk);
            bus(1'b0, CTM_OFS_CNT_HI, 8'h00);
            c = {q[1:0], 8'h00};
            bus(1'b0, CTM_OFS_CNT_LO, 8'h00);
            chk_bit((c | 10'(q[7:0])) != 10'h0, 1'b1);
        end
        wrb(CTM_OFS_CTRL0, 8'h00);
        wrb(CTM_OFS_STATUS, 8'h03);
        wrb(CTM_OFS_CTRL0, 8'h19);
        wait_irq(1'b1, 200);
        wrb(CTM_OFS_CTRL0, 8'h11);
        rdc(CTM_OFS_STATUS, 32'h2);
        wrb(CTM_OFS_STATUS, 8'h02);
        rdc(CTM_OFS_STATUS, 32'h0);
        wrb(CTM_OFS_CTRL0, 8'h18);
        wait_irq(1'b1, 1100);
        wrb(CTM_OFS_CTRL0, 8'h00);
        wrb(CTM_OFS_CMP_LO, 8'h10);
        wrb(CTM_OFS_CMP_HI, 8'h00);
        sel_pos <= 1'b1;
        sel_neg <= 1'b1;
        // Initial level high, so none and high keep it, low and toggle drop it.
        for (int k = 0; k < 4; k++) begin
            wrb(CTM_OFS_CTRL0, 8'h00);
            wrb(CTM_OFS_CTRL1, {2'b00, k[1:0], 4'b1001});
            wrb(CTM_OFS_CTRL0, 8'h18);
            wait_irq(1'b0, 100);
            repeat (2) @(posedge clk);
            chk_bit(pos, ~k[0]);
            chk_bit(neg, k[0]);
            chk_bit(pos_oe, 1'b1);
            chk_bit(neg_oe, 1'b1);
        end
        for (int k = 1; k < 4; k += 2) begin
            wrb(CTM_OFS_CTRL0, 8'h00);
            wrb(CTM_OFS_CMP_LO, 8'((k * 16) & 8'hFF));
            wrb(CTM_OFS_CMP_HI, 8'h00);
            wrb(CTM_OFS_CTRL1, 8'hA0);
            wrb(CTM_OFS_CTRL0, 8'h19);
            hi_n = 0;
            // The first period after switch-on stays at the initial level.
            repeat (128) @(posedge clk);
            repeat (256) begin
                @(posedge clk);
                hi_n += int'(pos === 1'b1);
            end
            chk_bit(hi_n >= k * 32 - 16 && hi_n <= k * 32 + 16, 1'b1);
        end
        sel_pos <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(pos_oe, 1'b0);
        test_done();
    end

endmodule : test_ctm_top

bind ctm_top ctm_checker u_chk (.CLOCK(CLOCK), .RSTN(RSTN),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PIN_SEL_OUT_POS(PIN_SEL_OUT_POS), .PIN_SEL_OUT_NEG(PIN_SEL_OUT_NEG),
    .TIMER_OUT_POS(TIMER_OUT_POS), .TIMER_OUT_POS_OE(TIMER_OUT_POS_OE),
    .TIMER_OUT_NEG(TIMER_OUT_NEG), .TIMER_OUT_NEG_OE(TIMER_OUT_NEG_OE));

`default_nettype wire
